/* File: src/conv_clock_divider.v */
// Divides the system clock into a one-cycle conversion-clock tick.
// Assumes divider field from the configuration register, same clock.
`default_nettype none
module conv_clock_divider (
  input  wire       clock,
  input  wire       rst,
  input  wire [2:0] divider,
  output reg        tick
);
  reg  [3:0] count;
  reg  [3:0] limit;
  always @* begin
    case (divider)
      3'h0:    limit = 4'h0;
      3'h1:    limit = 4'h1;
      3'h2:    limit = 4'h3;
      3'h3:    limit = 4'h7;
      default: limit = 4'hf;
    endcase
  end
  // Tick once every 1, 2, 4, 8 or 16 clocks
  always @(posedge clock) begin
    if (rst) begin
      count <= 4'h0;
      tick  <= 1'b0;
    end else if (count >= limit) begin
      count <= 4'h0;
      tick  <= 1'b1;
    end else begin
      count <= count + 4'h1;
      tick  <= 1'b0;
    end
  end
endmodule // conv_clock_divider
`default_nettype wire

/* File: src/result_formatter.v */
// Places a 12-bit result into the high and low result bytes.
// Assumes the result word and differential flag are held stable by the caller.
`default_nettype none
module result_formatter (
  input  wire [11:0] result,
  input  wire        left_align,
  input  wire        differential,
  output wire [7:0]  high_byte,
  output wire [7:0]  low_byte
);
  // Sign copy only for two's complement differential data
  wire [3:0] upper_fill = differential ? {4{result[11]}} : 4'h0;
  // Left or right placement
  assign high_byte = left_align ? result[11:4] : {upper_fill, result[11:8]};
  assign low_byte  = left_align ? {result[3:0], 4'h0} : result[7:0];
endmodule // result_formatter
`default_nettype wire

/* File: src/sar_adc_control_regs.v */
// Converter control, configuration and result registers with trigger sequencing.
// Assumes a same-clock register port and an analog core with a done strobe.
`include "sar_adc_defines.vh"
`default_nettype none
module sar_adc_control_regs (
  input  wire        clock,
  input  wire        rst,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire        timer3_overflow,
  input  wire        timer2_overflow,
  input  wire        external_start_input,
  input  wire        core_done,
  input  wire [11:0] core_result,
  input  wire        differential,
  input  wire        window_match,
  input  wire        interrupt_enable,
  output reg  [4:0]  amp_gain_code,
  output wire        converter_power,
  output wire        track,
  output wire        convert_start,
  output wire        sar_clock_tick,
  output reg         interrupt_request
);
  localparam ST_IDLE    = 3'b001;
  localparam ST_TRACK   = 3'b010;
  localparam ST_CONVERT = 3'b100;

  reg  [7:0] config_reg;
  reg        converter_enable;
  reg        track_mode_select;
  reg        conversion_done_flag;
  reg  [1:0] start_source_select;
  reg        window_match_flag;
  reg        left_align_select;
  reg  [2:0] state;
  reg  [3:0] track_count;
  reg  [11:0] result_word;
  reg        result_differential;
  reg        ext_meta;
  reg        ext_sync;
  reg        ext_prev;
  wire [7:0] result_high_byte;
  wire [7:0] result_low_byte;
  wire       tick;

  wire conversion_busy = (state != ST_IDLE);
  wire write_control   = reg_write && (reg_addr == `ADDR_CONTROL);
  wire write_config    = reg_write && (reg_addr == `ADDR_CONFIG);
  wire busy_write      = write_control && reg_wdata[`BIT_BUSY];
  wire ext_rise        = ext_sync && !ext_prev;

  // Select the start trigger
  reg trigger;
  always @* begin
    case (start_source_select)
      `SRC_SOFTWARE: trigger = busy_write;
      `SRC_TIMER3:   trigger = timer3_overflow;
      `SRC_EXTERNAL: trigger = ext_rise;
      `SRC_TIMER2:   trigger = timer2_overflow;
      default:       trigger = 1'b0;
    endcase
  end

  // Source field in effect is the one already stored
  wire start_req = converter_enable && trigger && !conversion_busy;
  wire conv_end  = (state == ST_CONVERT) && core_done;

  conv_clock_divider u_divider (
    .clock   (clock),
    .rst     (rst),
    .divider (config_reg[7:5]),
    .tick    (tick)
  );

  result_formatter u_format (
    .result       (result_word),
    .left_align   (left_align_select),
    .differential (result_differential),
    .high_byte    (result_high_byte),
    .low_byte     (result_low_byte)
  );

  // External start pin synchroniser
  always @(posedge clock) begin
    if (rst) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
      ext_prev <= 1'b1;
    end else begin
      ext_meta <= external_start_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Conversion sequencer
  always @(posedge clock) begin
    if (rst) begin
      state       <= ST_IDLE;
      track_count <= 4'h0;
    end else if (!converter_enable) begin
      state       <= ST_IDLE;
      track_count <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_req) begin
            // Low power modes other than external start track 3 conversion clocks first
            if (track_mode_select && start_source_select != `SRC_EXTERNAL) begin
              state       <= ST_TRACK;
              track_count <= 4'h0;
            end else begin
              state <= ST_CONVERT;
            end
          end
        end
        ST_TRACK: begin
          if (tick) begin
            if (track_count == `TRACK_CLOCKS - 4'h1) begin
              state <= ST_CONVERT;
            end
            track_count <= track_count + 4'h1;
          end
        end
        ST_CONVERT: begin
          if (core_done) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Start pulse to core when entering conversion
  reg entering_convert;
  always @* begin
    entering_convert = 1'b0;
    if (converter_enable) begin
      if (state == ST_IDLE && start_req &&
          !(track_mode_select && start_source_select != `SRC_EXTERNAL)) begin
        entering_convert = 1'b1;
      end
      if (state == ST_TRACK && tick && track_count == `TRACK_CLOCKS - 4'h1) begin
        entering_convert = 1'b1;
      end
    end
  end
  assign convert_start = entering_convert;
  assign sar_clock_tick = tick;
  assign converter_power = converter_enable;

  // Tracking control per mode
  assign track = converter_enable && (
                   !track_mode_select ? (state != ST_CONVERT) :
                   (start_source_select == `SRC_EXTERNAL) ? (!ext_sync && state != ST_CONVERT) :
                   (state == ST_TRACK));

  // Registers
  always @(posedge clock) begin
    if (rst) begin
      config_reg           <= `CONFIG_RESET;
      converter_enable     <= 1'b0;
      track_mode_select    <= 1'b0;
      conversion_done_flag <= 1'b0;
      start_source_select  <= `SRC_SOFTWARE;
      window_match_flag    <= 1'b0;
      left_align_select    <= 1'b0;
      result_word          <= 12'h000;
      result_differential  <= 1'b0;
      interrupt_request    <= 1'b0;
    end else begin
      if (write_config) begin
        config_reg <= reg_wdata & `CONFIG_MASK;
      end
      if (write_control) begin
        converter_enable    <= reg_wdata[`BIT_ENABLE];
        track_mode_select   <= reg_wdata[`BIT_TRACK_MODE];
        start_source_select <= reg_wdata[3:2];
        left_align_select   <= reg_wdata[`BIT_ALIGN];
      end
      // Flags: set wins over a software clear
      if (conv_end) begin
        conversion_done_flag <= 1'b1;
      end else if (write_control) begin
        conversion_done_flag <= reg_wdata[`BIT_DONE];
      end
      if (window_match) begin
        window_match_flag <= 1'b1;
      end else if (write_control) begin
        window_match_flag <= reg_wdata[`BIT_WINDOW];
      end
      if (conv_end) begin
        result_word         <= core_result;
        result_differential <= differential;
      end
      interrupt_request <= conv_end && interrupt_enable;
    end
  end

  // Gain decode to one-hot amplifier select
  always @* begin
    case (config_reg[2:0])
      `GAIN_1: amp_gain_code = 5'h01;
      `GAIN_2: amp_gain_code = 5'h02;
      `GAIN_4: amp_gain_code = 5'h04;
      `GAIN_8: amp_gain_code = 5'h08;
      3'h4, 3'h5: amp_gain_code = 5'h10;
      default: amp_gain_code = 5'h00;
    endcase
  end

  // Read mux; busy shows state
  always @* begin
    case (reg_addr)
      `ADDR_CONFIG:      reg_rdata = config_reg;
      `ADDR_RESULT_LOW:  reg_rdata = result_low_byte;
      `ADDR_RESULT_HIGH: reg_rdata = result_high_byte;
      `ADDR_CONTROL:     reg_rdata = {converter_enable, track_mode_select, conversion_done_flag,
                                      conversion_busy, start_source_select, window_match_flag,
                                      left_align_select};
      default:           reg_rdata = 8'h00;
    endcase
  end
endmodule // sar_adc_control_regs
`default_nettype wire

/* File: src/sar_adc_defines.vh */
// Constants for the converter control and result-register block.
// Assumes an 8-bit special function register port with byte addresses.
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH
`define ADDR_CONFIG      8'hbc
`define ADDR_RESULT_LOW  8'hbe
`define ADDR_RESULT_HIGH 8'hbf
`define ADDR_CONTROL     8'he8
`define CONFIG_RESET     8'h60
`define CONTROL_RESET    8'h00
`define CONFIG_MASK      8'he7
`define BIT_ENABLE       7
`define BIT_TRACK_MODE   6
`define BIT_DONE         5
`define BIT_BUSY         4
`define BIT_WINDOW       1
`define BIT_ALIGN        0
`define SRC_SOFTWARE     2'h0
`define SRC_TIMER3       2'h1
`define SRC_EXTERNAL     2'h2
`define SRC_TIMER2       2'h3
`define TRACK_CLOCKS     4'h3
`define GAIN_1           3'h0
`define GAIN_2           3'h1
`define GAIN_4           3'h2
`define GAIN_8           3'h3
`endif

/* File: tb/sar_adc_checker_assertions.sv */
// Checker for the converter control block, bound to its top module.
// Assumes synchronous active-high reset and combinational read data.
`default_nettype none
module sar_adc_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       core_done,
  input wire logic       interrupt_enable,
  input wire logic [4:0] amp_gain_code,
  input wire logic       converter_power,
  input wire logic       convert_start,
  input wire logic       sar_clock_tick,
  input wire logic       interrupt_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // Expected one-hot gain drive for a gain field
  function automatic logic [4:0] gx(input logic [2:0] g);
    gx = g[2] ? (g[1] ? 5'h00 : 5'h10) : 5'h01 << g[1:0];
  endfunction
  a_gain_decode:
    assert property (reg_addr == 8'hbc |-> amp_gain_code == gx(reg_rdata[2:0])) else $error("gain drive wrong");
  a_unused_zero:
    assert property (reg_addr == 8'hbc |-> reg_rdata[4:3] == 2'h0) else $error("unused bits set");
  a_power_bit:
    assert property (reg_addr == 8'he8 |-> converter_power == reg_rdata[7]) else $error("power differs");
  a_start_power:
    assert property (convert_start |-> converter_power) else $error("start while off");
  a_done_sticky:
    assert property ((reg_addr == 8'he8 && reg_rdata[5] && !reg_write) ##1 reg_addr == 8'he8 |-> reg_rdata[5])
      else $error("done flag lost");
  a_window_sticky:
    assert property ((reg_addr == 8'he8 && reg_rdata[1] && !reg_write) ##1 reg_addr == 8'he8 |-> reg_rdata[1])
      else $error("window flag lost");
  a_irq_pulse:
    assert property (interrupt_request |=> !interrupt_request) else $error("irq too long");
  a_irq_cause:
    assert property (interrupt_request |-> $past(interrupt_enable) && ($past(core_done) || $past(core_done, 2)))
      else $error("irq without cause");
  c_start: cover property (convert_start);
  c_irq: cover property (interrupt_request);
  c_tick: cover property (sar_clock_tick ##1 !sar_clock_tick);
endmodule // sar_adc_checker
bind sar_adc_control_regs sar_adc_checker u_chk (.clock, .rst, .reg_write, .reg_addr, .reg_rdata, .core_done,
  .interrupt_enable, .amp_gain_code, .converter_power, .convert_start, .sar_clock_tick, .interrupt_request);
`default_nettype wire

/* File: tb/sar_adc_control_regs_tb_top.sv */
// Testbench for the converter control block with a behavioural core.
// Assumes combinational read data and one-cycle write strobes.
`default_nettype none
module sar_adc_control_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst, reg_write, reg_read, timer3_overflow, timer2_overflow, external_start_input;
  logic        window_match, interrupt_enable, core_done, differential, converter_power, track, diff_value;
  logic        convert_start, sar_clock_tick, interrupt_request;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, c;
  logic [11:0] core_result, result_value;
  logic [4:0]  amp_gain_code;
  int          fails, checked, starts, dones, irqs, tk, tk0, cyc, p, q, n;
  sar_adc_control_regs dut (.clock, .rst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
    .timer3_overflow, .timer2_overflow, .external_start_input, .core_done, .core_result, .differential,
    .window_match, .interrupt_enable, .amp_gain_code, .converter_power, .track, .convert_start,
    .sar_clock_tick, .interrupt_request);
  sar_core_model core (.clock, .rst, .convert_start, .result_value, .diff_value, .core_done, .core_result,
    .differential);
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // Event counters and tracking-tick count before each start
  always @(posedge clock) begin
    cyc++;
    if (convert_start) begin
      starts++;
      tk0 = tk + sar_clock_tick;
    end
    tk = (track && !convert_start) ? tk + sar_clock_tick : 0;
    if (core_done)
      dones++;
    if (interrupt_request)
      irqs++;
    if (cyc == 20000) begin
      fails++;
      close_out;
    end
  end
  task chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clock);
    #1 reg_write = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1 reg_write = 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clock);
    #1 reg_addr = a;
    reg_read = 1;
    #1 chk(reg_rdata, e);
    reg_read = 0;
  endtask
  task pl(input logic a, b);
    @(posedge clock);
    #1 timer3_overflow = a;
    timer2_overflow = b;
    @(posedge clock);
    #1 timer3_overflow = 0;
    timer2_overflow = 0;
  endtask
  task wt(input int t);
    repeat (400) if (dones < t) @(posedge clock);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task close_out;
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1;
    {reg_write, reg_read, timer3_overflow, timer2_overflow, external_start_input, window_match} = 6'h00;
    {interrupt_enable, diff_value, reg_addr, reg_wdata, result_value} = {2'h2, 28'h0};
    repeat (2) @(posedge clock);
    #1 rst = 0;
    rd(8'hbc, 8'h60);
    rd(8'he8, 8'h00);
    rd(8'hbe, 8'h00);
    rd(8'hbf, 8'h00);
    rd(8'h55, 8'h00);
    chk(amp_gain_code, 5'h01);
    for (int g = 0; g < 8; g++) begin
      wr(8'hbc, {3'h1, 2'h3, g[2:0]});
      rd(8'hbc, {3'h1, 2'h0, g[2:0]});
      chk(amp_gain_code, g < 4 ? 5'h01 << g : (g < 6 ? 5'h10 : 5'h00));
    end
    wr(8'he8, 8'h80);
    for (int d = 0; d < 5; d++) begin
      wr(8'hbc, {d[2:0], 5'h00});
      p = 0;
      q = 0;
      repeat (40) begin
        @(posedge clock);
        #1 if (sar_clock_tick) begin
          if (p) break;
          p = 1;
          q = 0;
        end
        q++;
      end
      chk(q, 1 << d);
    end
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 4; s++) begin
        c = {1'b1, m[0], 2'h0, s[1:0], 2'h0};
        wr(8'he8, c);
        n = starts;
        if (s != 0) wr(8'he8, c | 8'h10);
        pl(s != 1, s != 3);
        repeat (8) @(posedge clock);
        chk(starts, n);
        if (s == 0) wr(8'he8, c | 8'h10);
        else if (s == 2) begin
          @(posedge clock);
          #1 external_start_input = 1;
        end
        else pl(s == 1, s == 3);
        wt(n + 1);
        chk(starts, n + 1);
        if (m == 1 && s != 2) chk(tk0, 3);
        if (s == 2) begin
          chk(track, m == 0);
          external_start_input = 0;
          repeat (4) @(posedge clock);
          #1 chk(track, 1);
        end
      end
    result_value = 12'ha5c;
    wr(8'he8, 8'h80);
    wr(8'he8, 8'h90);
    wt(starts);
    rd(8'hbf, 8'h0a);
    rd(8'hbe, 8'h5c);
    rd(8'he8, 8'ha0);
    wr(8'he8, 8'h81);
    rd(8'hbf, 8'ha5);
    rd(8'hbe, 8'hc0);
    result_value = 12'h9a7;
    diff_value = 1;
    wr(8'he8, 8'h91);
    wt(starts);
    rd(8'hbf, 8'h9a);
    rd(8'hbe, 8'h70);
    wr(8'he8, 8'h80);
    rd(8'hbf, 8'hf9);
    rd(8'hbe, 8'ha7);
    wr(8'hbe, 8'hff);
    rd(8'hbe, 8'ha7);
    @(posedge clock);
    #1 window_match = 1;
    @(posedge clock);
    #1 window_match = 0;
    rd(8'he8, 8'h82);
    wr(8'he8, 8'h80);
    rd(8'he8, 8'h80);
    chk(irqs, dones);
    n = starts;
    wr(8'he8, 8'h00);
    wr(8'he8, 8'h10);
    chk(converter_power, 0);
    chk(starts, n);
    close_out;
  end
endmodule // sar_adc_control_regs_tb_top
`default_nettype wire

/* File: tb/sar_core_model.sv */
// Behavioural analog core: answers each start with a done pulse.
// Assumes convert_start is a one-cycle pulse on the shared clock.
`default_nettype none
module sar_core_model #(parameter int LATENCY = 20) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        convert_start,
  input  wire logic [11:0] result_value,
  input  wire logic        diff_value,
  output var  logic        core_done,
  output var  logic [11:0] core_result,
  output var  logic        differential
);
  timeunit 1ns;
  timeprecision 1ps;
  int count;
  always @(posedge clock) begin
    core_done <= 1'b0;
    core_result <= ~result_value;
    differential <= ~diff_value;
    if (rst)
      count <= 0;
    else if (convert_start)
      count <= LATENCY;
    else if (count > 0) begin
      count <= count - 1;
      if (count == 1) begin
        core_done <= 1'b1;
        core_result <= result_value;
        differential <= diff_value;
      end
    end
  end
endmodule // sar_core_model
`default_nettype wire
